// ===== ccs_pkg.sv
// Overview of operation
// R1 - High-impedance force bit 7 of control one holds HIGH_IMPEDANCE_FORCE over enable pin and override.
// R2 - With the force bit at 0 the system may advance to power-on normally.
// R3 - Host must write the timer kick bit before the selected timeout expires.
// R4 - Writing 1 to kick restarts the timeout counter; the bit reads back 0.
// R5 - Control one bit 1 enables the 31.25kHz minimum switching frequency floor.
// R6 - Writing 1 to control one bit 0 restores all defaults; it reads back 0.
// R7 - Shutdown-disable at 0: eight consecutive current-limit cycles disable the device.
// R8 - Control two bit 4 selects switch peak current limit: 0 is 8.5A, 1 is 10A.
// R9 - Timeout field bits 1:0: 00 off, 01 80s, 10 160s, 11 320s.
// R10 - In high-impedance mode the timeout counter is held cleared.
// R11 - A disabled timeout selection also clears the timeout counter.
// R12 - General status bit 6 shows the live interrupt pin level.
// R13 - General status bit 5 shows the live enable pin level.
// R14 - General status bits 1:0 report 00 for HIGH_IMPEDANCE_FORCE, 10 for power-on only.
// R15 - Thermal status bit 6 reads 1 while thermal regulation is active.
// R16 - Host keeps reserved bits at defaults and ignores them on read.
// R17 - Timeout expiry with the timer enabled sets a latching timeout fault flag.
// R18 - Control two bit 2 turns the auxiliary LDO on when 1; default on.
package ccs_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h01;
	localparam logic [7:0] ADDR_GEN   = 8'h02;
	localparam logic [7:0] ADDR_THERM = 8'h03;
	// Field positions
	localparam int CTRL1_HIZ   = 7;
	localparam int CTRL1_KICK  = 2;
	localparam int CTRL1_AUDIO = 1;
	localparam int CTRL1_RRST  = 0;
	localparam int CTRL2_OCSD  = 6;
	localparam int CTRL2_ILIM  = 4;
	localparam int CTRL2_LDO   = 2;
	localparam int GEN_IRQ     = 6;
	localparam int GEN_EN      = 5;
	localparam int THERM_ACT   = 6;
	// Reset values and storable bits
	localparam logic [7:0] CTRL1_RST   = 8'h00;
	localparam logic [7:0] CTRL2_RST   = 8'hb4;
	localparam logic [7:0] CTRL1_WMASK = 8'h82;
	localparam logic [7:0] CTRL2_WMASK = 8'h57;
	localparam logic [7:0] ZERO_BYTE   = 8'h00;
	// Reported state codes
	localparam logic [1:0] CODE_HIZ = 2'h0;
	localparam logic [1:0] CODE_ON  = 2'h2;
	localparam logic [1:0] TMO_OFF  = 2'h0;
	localparam logic [1:0] TMO_X1   = 2'h1;
	localparam logic [1:0] TMO_X2   = 2'h2;
	// Consecutive limited cycles before shutdown
	localparam logic [4:0] OCP_RUN = 5'h08;
	// Timing
	localparam longint unsigned CLK_HZ       = 10_000_000;
	localparam longint unsigned TMO_BASE_S   = 80;
	localparam longint unsigned TMO_BASE_CYC = TMO_BASE_S * CLK_HZ;
	localparam logic [6:0]      I2C_ADDR_DEF = 7'h24;

	typedef enum logic [1:0] {
		CCS_HIZ = 2'b01,
		CCS_ON  = 2'b10
	} ccs_sys_t;

	typedef enum logic [5:0] {
		CCS_I_IDLE = 6'b000001,
		CCS_I_ADDR = 6'b000010,
		CCS_I_REG  = 6'b000100,
		CCS_I_WDAT = 6'b001000,
		CCS_I_RDAT = 6'b010000,
		CCS_I_ACK  = 6'b100000
	} ccs_i2c_st_t;

	typedef struct packed {
		logic       stb;
		logic [7:0] addr;
		logic [7:0] data;
	} ccs_wr_t;

	typedef struct packed {
		logic hiz_mode;
		logic power_on;
		logic audio_floor_en;
		logic ilim_high;
		logic ldo_on;
		logic ocp_shutdown;
		logic timeout_fault;
	} ccs_ctl_t;
endpackage : ccs_pkg

// ===== ccs_timeout.sv
`timescale 1ns/100ps
module ccs_timeout #(
	parameter longint unsigned BASE_CYC = ccs_pkg::TMO_BASE_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic [1:0] sel,
	input  wire logic       hold,
	input  wire logic       kick,
	output logic            expire
);
	logic [31:0] cnt_reg;
	logic [31:0] limit;

	// Period from the selection field
	always_comb begin
		unique case (sel)
			ccs_pkg::TMO_X1: limit = 32'(BASE_CYC);
			ccs_pkg::TMO_X2: limit = 32'(BASE_CYC * 2);
			default:         limit = 32'(BASE_CYC * 4);
		endcase
	end

	// Counter, cleared by kick, HIGH_IMPEDANCE_FORCE hold or disabled field
	always_ff @(posedge clk_sys) begin
		expire <= 1'b0;
		if (!resetn || kick || hold || sel == ccs_pkg::TMO_OFF) begin // [R4] [R10] [R11]
			cnt_reg <= 32'h0;
		end else if (cnt_reg == limit - 32'h1) begin // [R9]
			cnt_reg <= 32'h0;
			expire  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
		end
	end
endmodule : ccs_timeout

// ===== ccs_i2c_slave.sv
`timescale 1ns/100ps
module ccs_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = ccs_pkg::I2C_ADDR_DEF
) (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe_n,
	output logic [7:0]      ptr,
	input  wire logic [7:0] rd_data,
	output ccs_pkg::ccs_wr_t wr
);
	ccs_pkg::ccs_i2c_st_t st_reg;
	logic       scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic [7:0] sh_reg;
	logic [3:0] bcnt_reg;
	logic       rw_reg, have_ptr_reg, mack_reg;
	logic       scl_rise, scl_fall, start, stop;

	// Two-stage pin synchronisers plus edge history
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			{scl_s1, scl_s2, scl_d} <= 3'h7;
			{sda_s1, sda_s2, sda_d} <= 3'h7;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
		end
	end

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start    = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop     = scl_s2 & scl_d & ~sda_d & sda_s2;

	// Bus protocol: address, pointer, write bytes, read bytes with auto-increment
	always_ff @(posedge clk_sys) begin
		wr.stb <= 1'b0;
		if (!resetn) begin
			st_reg       <= ccs_pkg::CCS_I_IDLE;
			sda_oe_n     <= 1'b1;
			ptr          <= 8'h00;
			sh_reg       <= 8'h00;
			bcnt_reg     <= 4'h0;
			rw_reg       <= 1'b0;
			have_ptr_reg <= 1'b0;
			mack_reg     <= 1'b0;
			wr.addr      <= 8'h00;
			wr.data      <= 8'h00;
		end else if (start) begin
			st_reg       <= ccs_pkg::CCS_I_ADDR;
			sda_oe_n     <= 1'b1;
			bcnt_reg     <= 4'h0;
			have_ptr_reg <= 1'b0;
		end else if (stop) begin
			st_reg   <= ccs_pkg::CCS_I_IDLE;
			sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			// The master acknowledge clock of a read byte is not counted
			if (st_reg != ccs_pkg::CCS_I_ACK
				&& !(st_reg == ccs_pkg::CCS_I_RDAT && bcnt_reg == 4'h9)) begin
				bcnt_reg <= bcnt_reg + 4'h1;
			end
			if (st_reg == ccs_pkg::CCS_I_RDAT && bcnt_reg == 4'h9) begin
				mack_reg <= ~sda_s2; // Master acknowledge of a read byte
			end else if (st_reg != ccs_pkg::CCS_I_RDAT) begin
				sh_reg <= {sh_reg[6:0], sda_s2};
			end
		end else if (scl_fall) begin
			unique case (st_reg)
				ccs_pkg::CCS_I_IDLE: ;
				ccs_pkg::CCS_I_ADDR: if (bcnt_reg == 4'h8) begin
					if (sh_reg[7:1] == DEV_ADDR) begin
						rw_reg   <= sh_reg[0];
						sda_oe_n <= 1'b0;
						st_reg   <= ccs_pkg::CCS_I_ACK;
					end else begin
						st_reg <= ccs_pkg::CCS_I_IDLE;
					end
				end
				ccs_pkg::CCS_I_REG: if (bcnt_reg == 4'h8) begin
					ptr          <= sh_reg;
					have_ptr_reg <= 1'b1;
					sda_oe_n     <= 1'b0;
					st_reg       <= ccs_pkg::CCS_I_ACK;
				end
				ccs_pkg::CCS_I_WDAT: if (bcnt_reg == 4'h8) begin
					wr.stb   <= 1'b1;
					wr.addr  <= ptr;
					wr.data  <= sh_reg;
					ptr      <= ptr + 8'h1; // Next byte goes to the next offset
					sda_oe_n <= 1'b0;
					st_reg   <= ccs_pkg::CCS_I_ACK;
				end
				// End of acknowledge: first read bit, or next write byte
				ccs_pkg::CCS_I_ACK: begin
					bcnt_reg <= 4'h0;
					if (rw_reg) begin
						sh_reg   <= {rd_data[6:0], 1'b0};
						sda_oe_n <= rd_data[7];
						st_reg   <= ccs_pkg::CCS_I_RDAT;
					end else begin
						sda_oe_n <= 1'b1;
						st_reg   <= have_ptr_reg ? ccs_pkg::CCS_I_WDAT : ccs_pkg::CCS_I_REG;
					end
				end
				ccs_pkg::CCS_I_RDAT: begin
					if (bcnt_reg == 4'h8) begin
						ptr      <= ptr + 8'h1;
						sda_oe_n <= 1'b1;
						bcnt_reg <= 4'h9;
					end else if (bcnt_reg == 4'h9) begin
						if (mack_reg) begin
							bcnt_reg <= 4'h0;
							sh_reg   <= {rd_data[6:0], 1'b0};
							sda_oe_n <= rd_data[7];
						end else begin
							st_reg <= ccs_pkg::CCS_I_IDLE;
						end
					end else begin
						sda_oe_n <= sh_reg[7];
						sh_reg   <= {sh_reg[6:0], 1'b0};
					end
				end
				default: st_reg <= ccs_pkg::CCS_I_IDLE;
			endcase
		end
	end
endmodule : ccs_i2c_slave

// ===== ccs_regs.sv
`timescale 1ns/100ps
module ccs_regs #(
	parameter logic [6:0]      DEV_ADDR = ccs_pkg::I2C_ADDR_DEF,
	parameter longint unsigned BASE_CYC = ccs_pkg::TMO_BASE_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        en_pin,
	input  wire logic        irq_pin,
	input  wire logic        thermal_reg_in,
	input  wire logic        enable_override,
	input  wire logic        sw_cycle,
	input  wire logic        sw_limit_hit,
	output ccs_pkg::ccs_ctl_t ctl
);
	ccs_pkg::ccs_wr_t  wr;
	ccs_pkg::ccs_sys_t sys_reg;
	logic [7:0] ptr, rd_data, ctrl1_reg, ctrl2_reg, gen_stat, therm_stat;
	logic [4:0] run_reg;
	logic       en_s1, en_s2, irq_s1, irq_s2, th_s1, th_s2;
	logic       wr_c1, wr_c2, rrst, kick, expire, i2c_oe_n, ocp_trip;

	ccs_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_oe_n (i2c_oe_n),
		.ptr      (ptr),
		.rd_data  (rd_data),
		.wr       (wr)
	);

	// Write decode and self-clearing actions
	assign wr_c1 = wr.stb && wr.addr == ccs_pkg::ADDR_CTRL1;
	assign wr_c2 = wr.stb && wr.addr == ccs_pkg::ADDR_CTRL2;
	assign rrst  = wr_c1 && wr.data[ccs_pkg::CTRL1_RRST];  // [R6]
	assign kick  = (wr_c1 && wr.data[ccs_pkg::CTRL1_KICK]) || rrst; // [R4]
	// Eighth consecutive limited cycle with shutdown allowed
	assign ocp_trip = sw_cycle && sw_limit_hit && run_reg == ccs_pkg::OCP_RUN - 5'h1
		&& !ctrl2_reg[ccs_pkg::CTRL2_OCSD]; // [R7]

	ccs_timeout #(.BASE_CYC(BASE_CYC)) u_tmo (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.sel     (ctrl2_reg[1:0]),
		.hold    (sys_reg == ccs_pkg::CCS_HIZ), // [R10]
		.kick    (kick),
		.expire  (expire)
	);

	// Pin synchronisers
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			{en_s1, en_s2, irq_s1, irq_s2, th_s1, th_s2} <= 6'h0;
		end else begin
			{en_s1, en_s2} <= {en_pin, en_s1};
			{irq_s1, irq_s2} <= {irq_pin, irq_s1};
			{th_s1, th_s2} <= {thermal_reg_in, th_s1};
		end
	end

	// Control registers; reserved and self-clearing bits are never stored
	always_ff @(posedge clk_sys) begin
		if (!resetn || rrst) begin // [R6]
			ctrl1_reg <= ccs_pkg::CTRL1_RST;
			ctrl2_reg <= ccs_pkg::CTRL2_RST; // [R18]
		end else begin
			if (wr_c1) begin
				ctrl1_reg <= (wr.data & ccs_pkg::CTRL1_WMASK) | (ccs_pkg::CTRL1_RST & ~ccs_pkg::CTRL1_WMASK);
			end
			if (wr_c2) begin
				ctrl2_reg <= (wr.data & ccs_pkg::CTRL2_WMASK) | (ccs_pkg::CTRL2_RST & ~ccs_pkg::CTRL2_WMASK);
			end
		end
	end

	// System state: HIGH_IMPEDANCE_FORCE force wins over pin and override
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sys_reg <= ccs_pkg::CCS_HIZ;
		end else if (ctrl1_reg[ccs_pkg::CTRL1_HIZ] || ctl.ocp_shutdown) begin // [R1]
			sys_reg <= ccs_pkg::CCS_HIZ;
		end else if (en_s2 || enable_override) begin // [R2]
			sys_reg <= ccs_pkg::CCS_ON;
		end else begin
			sys_reg <= ccs_pkg::CCS_HIZ;
		end
	end

	// Consecutive current-limit cycle counter
	always_ff @(posedge clk_sys) begin
		if (!resetn || rrst || ctrl1_reg[ccs_pkg::CTRL1_HIZ]) begin
			run_reg <= 5'h0;
		end else if (sw_cycle) begin
			if (!sw_limit_hit || run_reg == ccs_pkg::OCP_RUN - 5'h1) begin
				run_reg <= 5'h0;
			end else begin
				run_reg <= run_reg + 5'h1;
			end
		end
	end

	// Shutdown latch; a trip in the cycle of a clear still sets it
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctl.ocp_shutdown <= 1'b0;
		end else if (ocp_trip) begin
			ctl.ocp_shutdown <= 1'b1; // [R7]
		end else if (rrst || ctrl1_reg[ccs_pkg::CTRL1_HIZ]) begin
			ctl.ocp_shutdown <= 1'b0;
		end
	end

	// Latching timeout fault; an expiry beats a simultaneous restore
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctl.timeout_fault <= 1'b0;
		end else if (expire) begin
			ctl.timeout_fault <= 1'b1; // [R17]
		end else if (rrst) begin
			ctl.timeout_fault <= 1'b0;
		end
	end

	// Registered control outputs
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctl.hiz_mode       <= 1'b1;
			ctl.power_on       <= 1'b0;
			ctl.audio_floor_en <= 1'b0;
			ctl.ilim_high      <= 1'b1;
			ctl.ldo_on         <= 1'b1;
		end else begin
			ctl.hiz_mode       <= sys_reg == ccs_pkg::CCS_HIZ;
			ctl.power_on       <= sys_reg == ccs_pkg::CCS_ON;
			ctl.audio_floor_en <= ctrl1_reg[ccs_pkg::CTRL1_AUDIO]; // [R5]
			ctl.ilim_high      <= ctrl2_reg[ccs_pkg::CTRL2_ILIM];  // [R8]
			ctl.ldo_on         <= ctrl2_reg[ccs_pkg::CTRL2_LDO];   // [R18]
		end
	end

	// Status bytes
	always_comb begin
		gen_stat = ccs_pkg::ZERO_BYTE;
		gen_stat[ccs_pkg::GEN_IRQ] = irq_s2; // [R12]
		gen_stat[ccs_pkg::GEN_EN]  = en_s2;  // [R13]
		gen_stat[1:0] = (sys_reg == ccs_pkg::CCS_ON) ? ccs_pkg::CODE_ON : ccs_pkg::CODE_HIZ; // [R14]
		therm_stat = ccs_pkg::ZERO_BYTE;
		therm_stat[ccs_pkg::THERM_ACT] = th_s2; // [R15]
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (ptr)
			ccs_pkg::ADDR_CTRL1: rd_data = ctrl1_reg;
			ccs_pkg::ADDR_CTRL2: rd_data = ctrl2_reg;
			ccs_pkg::ADDR_GEN:   rd_data = gen_stat;
			ccs_pkg::ADDR_THERM: rd_data = therm_stat;
			default:             rd_data = ccs_pkg::ZERO_BYTE;
		endcase
	end

	// Open-drain data line: only ever pulls low
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sda_out  <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			sda_out  <= 1'b0;
			sda_oe_n <= i2c_oe_n;
		end
	end
endmodule : ccs_regs

// ===== ccs_regs_assertions.sv
`timescale 1ns/100ps
module ccs_regs_assertions (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire logic              en_pin,
	input wire logic              enable_override,
	input wire logic              sw_cycle,
	input wire logic              sw_limit_hit,
	input wire ccs_pkg::ccs_ctl_t ctl
);
	logic [3:0] run_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Counts consecutive current-limited switching cycles
	always_ff @(posedge clk_sys) begin
		if (!resetn || run_cnt == 4'h8)
			run_cnt <= 4'h0;
		else if (sw_cycle)
			run_cnt <= sw_limit_hit ? run_cnt + 4'h1 : 4'h0;
	end
	AST_ONE_STATE: assert property (ctl.hiz_mode ^ ctl.power_on)
		else $error("state is not exactly one of off and on");
	AST_OCP_OFF: assert property (ctl.ocp_shutdown |-> ##2 ctl.hiz_mode)
		else $error("output on while shut down");
	AST_TRIP: assert property (run_cnt == 4'h8 |-> ##[0:2] ctl.ocp_shutdown)
		else $error("eight limited cycles did not shut down");
	AST_TRIP_CAUSE: assert property ($rose(ctl.ocp_shutdown) |-> run_cnt == 4'h8)
		else $error("shutdown without eight limited cycles");
	AST_NO_ENABLE: assert property ((!en_pin && !enable_override)[*7] |-> !ctl.power_on)
		else $error("on without any enable");
	AST_TMO_CAUSE: assert property ($rose(ctl.timeout_fault) |-> $past(ctl.power_on, 2))
		else $error("timeout fault while off");
	AST_RST_DEF: assert property ($rose(resetn) |-> ctl.ldo_on && ctl.ilim_high)
		else $error("reset defaults wrong");
	AST_TMO_STAY: assert property ($rose(ctl.timeout_fault) |=> ctl.timeout_fault[*8])
		else $error("timeout fault did not latch");
endmodule : ccs_regs_assertions

bind ccs_regs ccs_regs_assertions chk_u (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.en_pin(en_pin),
	.enable_override(enable_override),
	.sw_cycle(sw_cycle),
	.sw_limit_hit(sw_limit_hit),
	.ctl(ctl)
);

// ===== ccs_host_model.sv
`timescale 1ns/100ps
module ccs_host_model #(
	parameter logic [6:0] DEV = 7'h24
) (
	input  wire logic clk_sys,
	input  wire logic sda_oe_n,
	output logic      scl,
	output logic      sda
);
	logic       sda_m = 1'b1;
	logic       acked;
	logic [8:0] got;
	// Pulled-up line: low while either side pulls it
	assign sda = sda_m & sda_oe_n;
	initial scl = 1'b1;
	// Sets both lines and holds them for one bus phase
	task automatic drv(input logic s, input logic c);
		sda_m = s;
		scl = c;
		repeat (10) @(negedge clk_sys);
	endtask : drv
	// Start, also a repeated start after a byte
	task automatic st;
		drv(1'b1, scl);
		drv(1'b1, 1'b1);
		drv(1'b0, 1'b1);
		drv(1'b0, 1'b0);
	endtask : st
	task automatic sp;
		drv(1'b0, 1'b0);
		drv(1'b0, 1'b1);
		drv(1'b1, 1'b1);
	endtask : sp
	// Nine bits, data only changes while the clock is low
	task automatic xb(input logic [8:0] d);
		for (int i = 8; i >= 0; i--) begin
			drv(d[i], 1'b0);
			drv(d[i], 1'b1);
			got[i] = sda;
			drv(d[i], 1'b0);
		end
		acked = acked & !got[0];
	endtask : xb
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v);
		acked = 1'b1;
		st;
		xb({a, 2'b01});
		xb({r, 1'b1});
		xb({v, 1'b1});
		sp;
	endtask : wr
	task automatic rd(input logic [7:0] r, output logic [7:0] v);
		st;
		xb({DEV, 2'b01});
		xb({r, 1'b1});
		st;
		xb({DEV, 2'b11});
		xb(9'h1ff);
		v = got[8:1];
		sp;
	endtask : rd
endmodule : ccs_host_model

// ===== ccs_regs_bench.sv
`timescale 1ns/100ps
module ccs_regs_bench;
	localparam int BASE = 3000;
	logic              clk_sys = 1'b0;
	logic              resetn = 1'b0;
	logic              en_pin = 1'b0;
	logic              irq_pin = 1'b1;
	logic              therm = 1'b0;
	logic              ovr = 1'b0;
	logic              swc = 1'b0;
	logic              hit = 1'b0;
	logic              scl;
	logic              sda;
	logic              sda_oe_n;
	logic              sda_out;
	logic [7:0]        q;
	ccs_pkg::ccs_ctl_t ctl;
	int                failures = 0;
	int                n_tests = 0;
	ccs_regs #(.BASE_CYC(64'(BASE))) dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .en_pin(en_pin),
		.irq_pin(irq_pin), .thermal_reg_in(therm), .enable_override(ovr),
		.sw_cycle(swc), .sw_limit_hit(hit), .ctl(ctl));
	ccs_host_model host_u (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h wanted %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wt
	task automatic rchk(input logic [7:0] r, input logic [7:0] exp);
		host_u.rd(r, q);
		cmp(q, exp);
	endtask : rchk
	// Write on the device address, which must be acknowledged
	task automatic wreg(input logic [7:0] r, input logic [7:0] v);
		host_u.wr(ccs_pkg::I2C_ADDR_DEF, r, v);
		cmp({7'h00, host_u.acked}, 8'h01);
	endtask : wreg
	// Data pin drive level, then hiz, on, audio, ilim, ldo, ocp, timeout
	task automatic cctl(input logic [7:0] e);
		wt(8);
		cmp({sda_out, ctl}, e);
	endtask : cctl
	task automatic pulse(input int n, input logic h);
		repeat (n) begin
			swc = 1'b1;
			hit = h;
			wt(1);
			swc = 1'b0;
			wt(1);
		end
	endtask : pulse
	// Main sequence
	initial begin
		wt(12);
		resetn = 1'b1;
		wt(4);
		cctl(8'h4c);
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'hb4);
		en_pin = 1'b1;
		irq_pin = 1'b0;
		therm = 1'b1;
		cctl(8'h2c);
		rchk(8'h02, 8'h22);
		rchk(8'h03, 8'h40);
		en_pin = 1'b0;
		irq_pin = 1'b1;
		therm = 1'b0;
		cctl(8'h4c);
		rchk(8'h02, 8'h40);
		rchk(8'h03, 8'h00);
		en_pin = 1'b1;
		ovr = 1'b1;
		wreg(8'h00, 8'h86);
		cctl(8'h5c);
		rchk(8'h00, 8'h82);
		rchk(8'h02, 8'h60);
		wreg(8'h00, 8'h00);
		cctl(8'h2c);
		wreg(8'h01, 8'ha0);
		cctl(8'h20);
		rchk(8'h01, 8'ha0);
		wreg(8'h00, 8'h01);
		cctl(8'h2c);
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'hb4);
		wreg(8'h02, 8'hff);
		rchk(8'h02, 8'h62);
		rchk(8'h10, 8'h00);
		host_u.wr(7'h25, 8'h00, 8'h80);
		cmp({7'h00, host_u.acked}, 8'h00);
		cctl(8'h2c);
		pulse(7, 1'b1);
		pulse(1, 1'b0);
		pulse(7, 1'b1);
		cctl(8'h2c);
		pulse(1, 1'b1);
		cctl(8'h4e);
		wreg(8'h00, 8'h80);
		wreg(8'h00, 8'h00);
		cctl(8'h2c);
		for (int s = 1; s <= 3; s++) begin
			wreg(8'h01, 8'hb4 | 8'(s));
			wt(BASE * (1 << (s - 1)) * 3 / 4);
			cctl(8'h2c);
			wt(BASE * (1 << (s - 1)) / 2);
			cctl(8'h2d);
			wreg(8'h00, 8'h01);
		end
		wreg(8'h01, 8'hb5);
		wt(2000);
		wreg(8'h00, 8'h04);
		rchk(8'h00, 8'h00);
		wt(1500);
		cctl(8'h2c);
		wt(800);
		cctl(8'h2d);
		wreg(8'h00, 8'h01);
		wreg(8'h01, 8'hb5);
		wt(2000);
		wreg(8'h01, 8'hb4);
		wreg(8'h01, 8'hb5);
		wt(1000);
		cctl(8'h2c);
		wreg(8'h00, 8'h80);
		wt(4000);
		cctl(8'h4c);
		wreg(8'h00, 8'h00);
		wt(1500);
		cctl(8'h2c);
		en_pin = 1'b0;
		cctl(8'h2c);
		ovr = 1'b0;
		cctl(8'h4c);
		summarize;
	end
	// Cuts a hang short
	initial begin
		#10000000;
		failures++;
		summarize;
	end
endmodule : ccs_regs_bench
